// ==== rtl/php_parallel_host_port.sv ====
// Functional notes
// [RL1] All logic of this port runs from the one system clock, rated up to 66 MHz.
// [RL2] The hardware reset clears every register of the port asynchronously to its default.
// [RL3] The hardware reset is synchronized and merged with the software reset into one internal reset.
// [RL4] A high output-enable control floats all scan-side outputs.
// [RL5] The data bus is 16 bits wide, with a 5-bit address.
// [RL6] Transfers happen only while chip select is low; otherwise data and acknowledge float.
// [RL7] Read/write select high means a read cycle and low means a write cycle.
// [RL8] Strobe falling starts the data phase and strobe rising ends it.
// [RL9] Data drivers float whenever strobe is high, even in a read cycle.
// [RL10] The acknowledge is open drain: it either pulls low or floats.
// [RL11] In a write the acknowledge pulls low after the data is captured and floats when the cycle ends.
// [RL12] In a read the acknowledge pulls low only after valid data is on the bus and floats when the cycle ends.
// [RL13] The interrupt output is high whenever any enabled event is pending.
// [RL14] Chip select, strobe and read/write are synchronized before any cycle decoding.
// [RL15] The host holds address, select, direction and data stable while strobe is low and lifts it after acknowledge.
`timescale 1ns/100ps
`include "php_cfg.svh"
`default_nettype none

module php_parallel_host_port
  import php_pkg::*;
#(
  parameter int DATA_W = `PHP_DATA_W,
  parameter int ADDR_W = `PHP_ADDR_W,
  parameter int IRQ_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic i_chip_select_n,
  input wire logic i_read_not_write,
  input wire logic i_transfer_strobe_n,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_transfer_ack_n,
  output logic o_transfer_ack_oe_n,
  output logic o_wr_req,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [DATA_W-1:0] o_wr_data,
  output logic o_rd_req,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic [DATA_W-1:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic [IRQ_W-1:0] i_irq_pending,
  input wire logic [IRQ_W-1:0] i_irq_enable,
  output logic o_int,
  input wire logic i_scan_output_disable,
  input wire logic i_scan_tdo,
  input wire logic i_scan_tms,
  input wire logic i_scan_tck,
  output logic o_scan_tdo,
  output logic o_scan_tms,
  output logic o_scan_tck,
  output logic o_scan_oe_n,
  output logic o_internal_sync_reset_n
);

  localparam int CTL_W = 3 + ADDR_W + DATA_W + 1;

  // Pin synchronizers: stage one is read only by stage two
  logic [CTL_W-1:0] pin_meta;
  logic [CTL_W-1:0] pin_sync;
  logic [CTL_W-1:0] next_pin_meta;
  logic [CTL_W-1:0] next_pin_sync;
  logic [1:0] rst_sync;
  logic [1:0] next_rst_sync;

  logic cs_n_s;
  logic rnw_s;
  logic stb_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic oe_dis_s;

  php_state_t state;
  php_state_t next_state;
  logic [DATA_W-1:0] next_data;
  logic next_data_oe_n;
  logic next_ack_oe_n;
  logic next_wr_req;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;
  logic next_rd_req;
  logic [ADDR_W-1:0] next_rd_addr;
  logic next_int;
  logic next_scan_tdo;
  logic next_scan_tms;
  logic next_scan_tck;
  logic next_scan_oe_n;
  logic cycle_live;

  always_comb begin
    next_pin_meta = {i_chip_select_n, i_read_not_write, i_transfer_strobe_n, i_address, i_data,
                     i_scan_output_disable}; // [RL14]
    next_pin_sync = pin_meta;
    // Soft reset passes its own two-stage synchronizer, as deep as the pin synchronizer
    next_rst_sync = {rst_sync[0], ~i_soft_rst}; // [RL3]
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin // [RL2]
      pin_meta <= {1'h1, 1'h1, 1'h1, {ADDR_W{1'h0}}, {DATA_W{1'h0}}, 1'h1};
      pin_sync <= {1'h1, 1'h1, 1'h1, {ADDR_W{1'h0}}, {DATA_W{1'h0}}, 1'h1};
      rst_sync <= ~`PHP_SYNC_RST;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      rst_sync <= next_rst_sync;
    end
  end

  assign {cs_n_s, rnw_s, stb_n_s, addr_s, data_s, oe_dis_s} = pin_sync;
  assign o_internal_sync_reset_n = rst_sync[1]; // [RL3]

  // Transfer FSM; all decoding uses synchronized pins only
  always_comb begin
    cycle_live = ~cs_n_s & ~stb_n_s; // [RL6] [RL8]
    next_state = state;
    next_data = o_data;
    next_wr_req = 1'h0;
    next_wr_addr = o_wr_addr;
    next_wr_data = o_wr_data;
    next_rd_req = 1'h0;
    next_rd_addr = o_rd_addr;
    case (state)
      PHP_IDLE: begin
        if (cycle_live) begin // [RL8]
          if (rnw_s) begin // [RL7]
            next_state = PHP_RD_REQUEST;
          end else begin
            next_state = PHP_WR_CAPTURE;
          end
        end
      end
      PHP_WR_CAPTURE: begin
        // Host holds data stable while strobe is low
        next_wr_req = 1'h1; // [RL15]
        next_wr_addr = addr_s;
        next_wr_data = data_s;
        next_state = PHP_ACK;
      end
      PHP_RD_REQUEST: begin
        next_rd_req = 1'h1;
        next_rd_addr = addr_s;
        next_state = PHP_RD_WAIT;
      end
      PHP_RD_WAIT: begin
        if (!cycle_live) begin
          next_state = PHP_FINISH;
        end else if (i_rd_valid) begin
          next_data = i_rd_data;
          next_state = PHP_RD_DRIVE;
        end
      end
      PHP_RD_DRIVE: begin
        // One cycle with data driven before acknowledge falls
        next_state = cycle_live ? PHP_ACK : PHP_FINISH; // [RL12]
      end
      PHP_ACK: begin
        if (!cycle_live) begin // [RL8]
          next_state = PHP_FINISH;
        end
      end
      PHP_FINISH: begin
        next_state = PHP_IDLE;
      end
      default: begin
        next_state = PHP_IDLE;
      end
    endcase
    // Drivers follow the next state so they line up with it
    next_data_oe_n = ~(rnw_s & cycle_live & ((next_state == PHP_RD_DRIVE) |
                     ((next_state == PHP_ACK) & (state != PHP_WR_CAPTURE) & (state != PHP_IDLE)))); // [RL9] [RL6]
    next_ack_oe_n = ~(cycle_live & (next_state == PHP_ACK)); // [RL10] [RL11] [RL12]
    if (state == PHP_ACK && !rnw_s) begin
      next_data_oe_n = 1'h1;
    end
    next_int = |(i_irq_pending & i_irq_enable); // [RL13]
    next_scan_oe_n = oe_dis_s; // [RL4]
    next_scan_tdo = i_scan_tdo;
    next_scan_tms = i_scan_tms;
    next_scan_tck = i_scan_tck;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin // [RL1]
    if (i_rst) begin // [RL2]
      state <= PHP_IDLE;
      o_data <= {DATA_W{1'h0}}; // [RL5]
      o_data_oe_n <= `PHP_DATA_OE_N_RST;
      o_transfer_ack_oe_n <= `PHP_ACK_OE_N_RST;
      o_wr_req <= 1'h0;
      o_wr_addr <= {ADDR_W{1'h0}};
      o_wr_data <= {DATA_W{1'h0}};
      o_rd_req <= 1'h0;
      o_rd_addr <= {ADDR_W{1'h0}};
      o_int <= 1'h0;
      o_scan_oe_n <= `PHP_SCAN_OE_N_RST;
      o_scan_tdo <= 1'h0;
      o_scan_tms <= `PHP_SCAN_TMS_RST;
      o_scan_tck <= 1'h0;
      o_transfer_ack_n <= 1'h0;
    end else begin
      state <= next_state;
      o_data <= next_data;
      o_data_oe_n <= next_data_oe_n;
      o_transfer_ack_oe_n <= next_ack_oe_n;
      o_wr_req <= next_wr_req;
      o_wr_addr <= next_wr_addr;
      o_wr_data <= next_wr_data;
      o_rd_req <= next_rd_req;
      o_rd_addr <= next_rd_addr;
      o_int <= next_int;
      o_scan_oe_n <= next_scan_oe_n;
      o_scan_tdo <= next_scan_tdo;
      o_scan_tms <= next_scan_tms;
      o_scan_tck <= next_scan_tck;
      // Open drain: the output level is always low, only the enable moves
      o_transfer_ack_n <= 1'h0; // [RL10]
    end
  end

endmodule

`default_nettype wire

// ==== include/php_cfg.svh ====
`ifndef PHP_CFG_SVH
`define PHP_CFG_SVH

`define PHP_ADDR_W 5
`define PHP_DATA_W 16
`define PHP_CLK_MHZ 40
`define PHP_CLK_MAX_MHZ 66
`define PHP_ACK_OE_N_RST 1'h1
`define PHP_DATA_OE_N_RST 1'h1
`define PHP_SCAN_OE_N_RST 1'h1
`define PHP_SCAN_TMS_RST 1'h1
`define PHP_SYNC_RST 2'h3

`endif

// ==== include/php_pkg.sv ====
`default_nettype none
package php_pkg;

  typedef enum logic [2:0] {
    PHP_IDLE,
    PHP_WR_CAPTURE,
    PHP_RD_REQUEST,
    PHP_RD_WAIT,
    PHP_RD_DRIVE,
    PHP_ACK,
    PHP_FINISH
  } php_state_t;

endpackage
`default_nettype wire

// ==== dv/php_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module php_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic i_chip_select_n,
  input wire logic i_read_not_write,
  input wire logic i_transfer_strobe_n,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_irq_pending,
  input wire logic [7:0] i_irq_enable,
  input wire logic o_data_oe_n,
  input wire logic o_transfer_ack_n,
  input wire logic o_transfer_ack_oe_n,
  input wire logic o_wr_req,
  input wire logic o_rd_req,
  input wire logic o_int,
  input wire logic o_internal_sync_reset_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Five samples allow for the pin synchronizer and the registered enables
  property p_cs_float; i_chip_select_n [*5] |-> o_transfer_ack_oe_n && o_data_oe_n; endproperty
  a_cs_float: assert property (p_cs_float) else $error("bus driven while deselected");
  property p_stb_float; i_transfer_strobe_n [*5] |-> o_data_oe_n; endproperty
  a_stb_float: assert property (p_stb_float) else $error("data driven with strobe high");
  property p_ack_od; !o_transfer_ack_n; endproperty
  a_ack_od: assert property (p_ack_od) else $error("ack drives high");
  // Ack may only pull low for a cycle whose pins were live three samples back
  property p_ack_live; !o_transfer_ack_oe_n |-> !$past(i_chip_select_n, 3) && !$past(i_transfer_strobe_n, 3); endproperty
  a_ack_live: assert property (p_ack_live) else $error("ack pulled outside a cycle");
  property p_wr_ack; o_wr_req |-> !$past(i_read_not_write) ##1 !o_transfer_ack_oe_n && !o_wr_req; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write ack late");
  property p_rd_req; o_rd_req |-> $past(i_read_not_write) ##1 !o_rd_req && o_data_oe_n; endproperty
  a_rd_req: assert property (p_rd_req) else $error("bad read request");
  property p_rd_ack; $fell(o_data_oe_n) |-> $past(i_rd_valid) ##1 $fell(o_transfer_ack_oe_n); endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read ack not after data");
  // Skips the edges right after a reset, where the flag still shows its reset level
  property p_int; $past(o_internal_sync_reset_n) |-> o_int == $past(|(i_irq_pending & i_irq_enable)); endproperty
  a_int: assert property (p_int) else $error("interrupt level wrong");
  property p_soft; i_soft_rst [*3] |-> !o_internal_sync_reset_n; endproperty
  a_soft: assert property (p_soft) else $error("soft reset ignored");
  c_wr: cover property (o_wr_req);
  c_rd: cover property (o_rd_req);
  c_int: cover property ($rose(o_int));
endmodule
bind php_parallel_host_port php_asserts php_asserts_i (.i_sys_clk, .i_rst, .i_soft_rst, .i_chip_select_n,
  .i_read_not_write, .i_transfer_strobe_n, .i_rd_valid, .i_irq_pending, .i_irq_enable, .o_data_oe_n,
  .o_transfer_ack_n, .o_transfer_ack_oe_n, .o_wr_req, .o_rd_req, .o_int, .o_internal_sync_reset_n);
`default_nettype wire

// ==== dv/php_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module php_host_model (
  input wire logic i_sys_clk,
  input wire logic i_ack_n,
  input wire logic [15:0] i_data,
  output logic o_cs_n,
  output logic o_rnw,
  output logic o_stb_n,
  output logic [4:0] o_addr,
  output logic [15:0] o_data
);
  initial {o_cs_n, o_rnw, o_stb_n, o_addr, o_data} = '1;
  task automatic xfer(input logic cs_n, rnw, input logic [4:0] a, input logic [15:0] d, input logic [2:0] hold);
    int n;
    @(negedge i_sys_clk);
    {o_cs_n, o_rnw, o_addr, o_stb_n} = {cs_n, rnw, a, 1'b0};
    o_data = rnw ? ~o_data : d;
    for (n = 0; n < 40 && i_ack_n !== 1'b0; n++) @(negedge i_sys_clk);
    if (n == 40 && !cs_n) tb_top.give_up();
    repeat (hold) @(negedge i_sys_clk);
    {o_cs_n, o_stb_n} = 2'h3;
    // Released lines invert so a stale value never passes
    o_data = ~o_data;
    for (n = 0; n < 40 && i_ack_n === 1'b0; n++) @(negedge i_sys_clk);
    if (n == 40) tb_top.give_up();
    repeat (3) @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 0, i_rst = 1, i_soft_rst = 0, i_chip_select_n, i_read_not_write, i_transfer_strobe_n;
  logic i_rd_valid = 0, i_scan_output_disable = 0, i_scan_tdo = 0, i_scan_tms = 0, i_scan_tck = 0;
  logic o_data_oe_n, o_transfer_ack_n, o_transfer_ack_oe_n, o_wr_req, o_rd_req, o_int, o_scan_tdo;
  logic o_scan_tms, o_scan_tck, o_scan_oe_n, o_internal_sync_reset_n;
  logic [4:0] i_address, o_wr_addr, o_rd_addr;
  logic [15:0] i_data, host_d, o_data, o_wr_data, i_rd_data = 0;
  logic [7:0] i_irq_pending = 0, i_irq_enable = 0;
  logic [31:0] seed = 32'h30;
  logic [1:0] dis_h = 2'h0;
  logic [20:0] q[$];
  int err_count = 0, checked = 0, rd_dly = 1, age = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  assign i_data = o_data_oe_n ? host_d : o_data;
  php_parallel_host_port php_parallel_host_port_i (.i_sys_clk, .i_rst, .i_soft_rst, .i_chip_select_n,
    .i_read_not_write, .i_transfer_strobe_n, .i_address, .i_data, .o_data, .o_data_oe_n, .o_transfer_ack_n,
    .o_transfer_ack_oe_n, .o_wr_req, .o_wr_addr, .o_wr_data, .o_rd_req, .o_rd_addr, .i_rd_data, .i_rd_valid,
    .i_irq_pending, .i_irq_enable, .o_int, .i_scan_output_disable, .i_scan_tdo, .i_scan_tms, .i_scan_tck,
    .o_scan_tdo, .o_scan_tms, .o_scan_tck, .o_scan_oe_n, .o_internal_sync_reset_n);
  // Open-drain ack with pull-up: floating reads high
  php_host_model php_host_model_i (.i_sys_clk, .i_ack_n(o_transfer_ack_oe_n | o_transfer_ack_n), .i_data,
    .o_cs_n(i_chip_select_n), .o_rnw(i_read_not_write), .o_stb_n(i_transfer_strobe_n), .o_addr(i_address),
    .o_data(host_d));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [20:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    finish_test();
  endtask
  // Scan enable passes two sync stages and a register, the scan levels only a register
  always @(negedge i_sys_clk) begin
    if (age >= 3) begin
      chk(21'(o_scan_oe_n), 21'(dis_h[1]));
      chk(21'({o_scan_tdo, o_scan_tms, o_scan_tck}), 21'({i_scan_tdo, i_scan_tms, i_scan_tck}));
    end
    age <= i_rst ? 0 : (age < 3 ? age + 1 : age);
    dis_h <= {dis_h[0], i_scan_output_disable};
    {i_irq_pending, i_irq_enable, i_scan_tdo, i_scan_tms, i_scan_tck, i_scan_output_disable} <= 20'(rnd());
  end
  // Outputs are looked at on the falling edge, well away from the edge that moves them
  always @(negedge i_sys_clk) if (o_rd_req === 1'b1) begin
    repeat (rd_dly) @(negedge i_sys_clk);
    i_rd_valid = 1;
    @(negedge i_sys_clk) i_rd_valid = 0;
  end
  always @(negedge i_sys_clk) if (o_wr_req === 1'b1 || (o_data_oe_n === 1'b0 && $fell(o_transfer_ack_oe_n))) begin
    chk(o_wr_req ? {o_wr_addr, o_wr_data} : {o_rd_addr, o_data}, q.size() ? q.pop_front() : 21'h0);
  end
  initial begin
    logic [31:0] w;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst = 0;
    for (int i = 0; i < 40; i++) begin
      w = rnd();
      i_rd_data = w[31:16];
      rd_dly = 1 + w[11:10];
      if (w[1:0] != 2'h2) q.push_back({w[9:5], w[31:16]});
      php_host_model_i.xfer(w[1:0] == 2'h2, w[1:0] == 2'h1, w[9:5], w[31:16], w[4:2]);
      if (i == 20) begin
        i_soft_rst = 1;
        repeat (3) @(negedge i_sys_clk);
        chk(21'(o_internal_sync_reset_n), 21'h0);
        i_soft_rst = 0;
        repeat (4) @(negedge i_sys_clk);
        chk(21'(o_internal_sync_reset_n), 21'h1);
      end
    end
    chk(21'(q.size()), 21'h0);
    finish_test();
  end
endmodule
`default_nettype wire
